// File: src/ros_relay_switch.sv
// relay output switch control for one channel, apb register access
// assumes a single clock; telegrams arrive as apb writes from a bus interface
//
// Summary of operation
// RQ1: normally-open channel: switch object 1 closes contact, 0 opens it
// RQ2: normally-closed channel inverts the switch object value
// RQ3: forcing decides the contact over a new switch value
// RQ4: permanent-on value 1 holds contact on until written 0
// RQ5: staircase keeps running under permanent-on; its state applies on release
// RQ6: download completion or bus voltage recovery clears permanent-on
// RQ7: inhibit 1 stops staircase triggering; plain on/off only; 0 re-enables
// RQ8: writing inhibit does not move the contact; setting it here masks a running staircase, which can move it
// RQ9: on bus voltage recovery inhibit loads the configured value
// RQ10: scene byte: bit7 store/recall, bit6 ignored, low six bits scene
// RQ11: scene field 0..63 names scenes 1..64
// RQ12: store records current switch state, only if storing permitted
// RQ13: recall applies the stored state of the addressed scene
// RQ14: channel objects are eight consecutive numbers from 10, stride eight
// RQ15: force code 0/1 releases, 2 forces off, 3 forces on
// RQ16: forcing and bus failure outrank ordinary switching
// RQ17: store while not permitted changes nothing
// RQ18: contact command registered; reset clears override and scenes
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ros_relay_switch #(
  parameter logic [1:0] CHANNEL = 2'h0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic relay_on
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int NUM_W = ros_pkg::NUM_SCENES;
  typedef struct packed {
    logic [NUM_W-1:0] scenes;
    logic nc;
    logic store_en;
    logic inh_init;
    logic sw;
    logic perm;
    logic inhibit;
    logic [1:0] force_v;
    logic stair;
    logic busfail;
    logic busfail_val;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic relay;
  } ros_state_t;

  ros_state_t s_q;
  ros_state_t s_d;
  logic acc;
  logic wr;
  logic [5:0] snum;
  logic base;
  logic logical;

  assign acc = psel && penable && !s_q.ready;
  assign wr = acc && pwrite;
  assign snum = pwdata[ros_pkg::SCENE_NUM_W-1:0]; // RQ10 RQ11
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.ready = acc;
    s_d.err = 1'b0;
    base = 1'b0;
    logical = 1'b0;
    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    if (acc && !pwrite)
    begin
      unique case (paddr)
        ros_pkg::ADDR_CTRL:
          s_d.rdata = {29'h0, s_q.inh_init, s_q.store_en, s_q.nc};
        ros_pkg::ADDR_OBJ:
          s_d.rdata = {23'h0, s_q.busfail_val, s_q.busfail, s_q.stair, s_q.force_v,
                       1'b0, s_q.inhibit, s_q.perm, s_q.sw};
        ros_pkg::ADDR_STATUS:
          s_d.rdata = {31'h0, s_q.relay};
        ros_pkg::ADDR_OBJBASE:
          s_d.rdata = {24'h0, ros_pkg::OBJ_FIRST + {6'h0, CHANNEL} * ros_pkg::OBJ_STRIDE}; // RQ14
        default:
        begin
          s_d.rdata = 32'h0;
          s_d.err = 1'b1;
        end
      endcase
    end
    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr)
    begin
      unique case (paddr)
        ros_pkg::ADDR_CTRL:
        begin
          s_d.nc = pwdata[ros_pkg::CTRL_NC];
          s_d.store_en = pwdata[ros_pkg::CTRL_STORE_EN];
          s_d.inh_init = pwdata[ros_pkg::CTRL_INH_INIT];
          if (pwdata[ros_pkg::CTRL_RECOVER] || pwdata[ros_pkg::CTRL_DOWNLOAD])
            s_d.perm = 1'b0; // RQ6
          if (pwdata[ros_pkg::CTRL_RECOVER])
            s_d.inhibit = pwdata[ros_pkg::CTRL_INH_INIT]; // RQ9
        end
        ros_pkg::ADDR_OBJ:
        begin
          if (pwdata[ros_pkg::OBJ_WE_SWITCH])
            s_d.sw = pwdata[ros_pkg::OBJ_SWITCH];
          if (pwdata[ros_pkg::OBJ_WE_PERM])
            s_d.perm = pwdata[ros_pkg::OBJ_PERM]; // RQ4
          // inhibit alone leaves the contact where it is unless setting it masks a running staircase
          if (pwdata[ros_pkg::OBJ_WE_INHIBIT])
            s_d.inhibit = pwdata[ros_pkg::OBJ_INHIBIT]; // RQ7 RQ8
          if (pwdata[ros_pkg::OBJ_WE_FORCE])
            s_d.force_v = pwdata[ros_pkg::OBJ_FORCE_LO +: 2];
          // staircase state comes from outside; ignored while inhibited
          s_d.stair = pwdata[ros_pkg::OBJ_STAIR] && !s_d.inhibit; // RQ7 RQ5
          s_d.busfail = pwdata[ros_pkg::OBJ_BUSFAIL];
          s_d.busfail_val = pwdata[ros_pkg::OBJ_BUSFAIL_VAL];
        end
        ros_pkg::ADDR_SCENE:
        begin
          if (pwdata[ros_pkg::SCENE_STORE_BIT])
          begin
            // store records the switch object value sw, not the staircase; refused silently if not permitted
            if (s_q.store_en)
              s_d.scenes[snum] = s_q.sw; // RQ12 RQ17
          end
          else
          begin
            s_d.sw = s_q.scenes[snum]; // RQ13
          end
        end
        default:
          s_d.err = 1'b1;
      endcase
    end
    // ----------------------------------------------------------------
    // contact priority
    // ----------------------------------------------------------------
    // ordinary result: switch object or running staircase
    logical = s_d.sw || s_d.stair;
    // normally-closed channel inverts the telegram sense
    base = s_d.nc ? !logical : logical; // RQ1 RQ2
    // priority: bus failure, forcing, permanent-on, ordinary
    if (s_d.busfail)
      s_d.relay = s_d.busfail_val; // RQ16
    else if (s_d.force_v == ros_pkg::FORCE_OFF)
      s_d.relay = 1'b0; // RQ15 RQ3
    else if (s_d.force_v == ros_pkg::FORCE_ON)
      s_d.relay = 1'b1; // RQ15 RQ3
    else if (s_d.perm)
      s_d.relay = 1'b1; // RQ4 RQ5
    else
      s_d.relay = base;
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0; // RQ18
    else
      s_q <= s_d; // RQ18
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign relay_on = s_q.relay;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // access decodes used only by the checks below
  logic wr_ctrl;
  logic wr_obj;
  logic wr_scene;
  logic rd_acc;
  assign wr_ctrl = wr && (paddr == ros_pkg::ADDR_CTRL);
  assign wr_obj = wr && (paddr == ros_pkg::ADDR_OBJ);
  assign wr_scene = wr && (paddr == ros_pkg::ADDR_SCENE);
  assign rd_acc = acc && !pwrite;

  a_perm_holds_on: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ4
    (s_q.perm && !s_q.busfail && !s_q.force_v[1]) |-> relay_on)
    else $error("permanent on not holding relay");

  a_perm_release: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ5
    ($fell(s_q.perm) && !s_q.busfail && !s_q.force_v[1])
      |-> relay_on == (s_q.nc ^ (s_q.sw || s_q.stair)))
    else $error("release did not restore background state");

  a_force_off_wins: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ15
    (s_q.force_v == ros_pkg::FORCE_OFF && !s_q.busfail) |-> !relay_on)
    else $error("force off not applied");

  a_force_on_wins: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ15
    (s_q.force_v == ros_pkg::FORCE_ON && !s_q.busfail) |-> relay_on)
    else $error("force on not applied");

  a_force_beats_sw: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ3
    (wr_obj && pwdata[ros_pkg::OBJ_WE_SWITCH] && !pwdata[ros_pkg::OBJ_WE_FORCE]
      && !pwdata[ros_pkg::OBJ_BUSFAIL] && s_q.force_v == ros_pkg::FORCE_ON) |=> relay_on)
    else $error("switch write moved a forced contact");

  a_busfail_first: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ16
    s_q.busfail |-> relay_on == s_q.busfail_val)
    else $error("bus failure value not applied");

  a_no_open_plain: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
    (!s_q.force_v[1] && !s_q.busfail && !s_q.perm && !s_q.nc)
      |-> relay_on == (s_q.sw || s_q.stair))
    else $error("normally open mapping wrong");

  a_nc_plain: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ2
    (!s_q.force_v[1] && !s_q.busfail && !s_q.perm && s_q.nc)
      |-> relay_on == !(s_q.sw || s_q.stair))
    else $error("normally closed mapping wrong");

  a_recover_clears: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ6
    (wr_ctrl && pwdata[ros_pkg::CTRL_RECOVER]) |=> !s_q.perm)
    else $error("recovery did not clear permanent on");

  a_download_clears: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ6
    (wr_ctrl && pwdata[ros_pkg::CTRL_DOWNLOAD]) |=> !s_q.perm)
    else $error("download did not clear permanent on");

  a_recover_inhibit: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ9
    (wr_ctrl && pwdata[ros_pkg::CTRL_RECOVER])
      |=> s_q.inhibit == $past(pwdata[ros_pkg::CTRL_INH_INIT]))
    else $error("recovery did not load inhibit");

  a_stair_masked: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ7
    wr_obj |=> !(s_q.inhibit && s_q.stair))
    else $error("staircase active while inhibited");

  a_inhibit_still: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ8
    (wr_obj && pwdata[ros_pkg::OBJ_WE_INHIBIT] && !pwdata[ros_pkg::OBJ_WE_SWITCH]
      && !pwdata[ros_pkg::OBJ_WE_PERM] && !pwdata[ros_pkg::OBJ_WE_FORCE]
      && pwdata[ros_pkg::OBJ_BUSFAIL] == s_q.busfail
      && pwdata[ros_pkg::OBJ_BUSFAIL_VAL] == s_q.busfail_val
      && !pwdata[ros_pkg::OBJ_STAIR] && !s_q.stair) |=> $stable(relay_on))
    else $error("inhibit write moved contact");

  a_sw_persists: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ8
    (wr_obj && !pwdata[ros_pkg::OBJ_WE_SWITCH]) |=> $stable(s_q.sw))
    else $error("switch state moved without a switch write");

  a_recall_keeps: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ10
    (wr_scene && !pwdata[ros_pkg::SCENE_STORE_BIT]) |=> $stable(s_q.scenes))
    else $error("recall changed stored scenes");

  a_store_records: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ12
    (wr_scene && pwdata[ros_pkg::SCENE_STORE_BIT] && s_q.store_en)
      |=> s_q.scenes[$past(snum)] == $past(s_q.sw))
    else $error("store did not record switch state");

  a_store_one_slot: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ11
    (wr_scene && pwdata[ros_pkg::SCENE_STORE_BIT] && s_q.store_en)
      |=> ((s_q.scenes ^ $past(s_q.scenes)) & ~(64'h1 << $past(snum))) == 64'h0)
    else $error("store touched another scene slot");

  a_store_refused: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ17
    (wr_scene && pwdata[ros_pkg::SCENE_STORE_BIT] && !s_q.store_en) |=> $stable(s_q.scenes))
    else $error("refused store changed scenes");

  a_refused_keeps_sw: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ17
    (wr_scene && pwdata[ros_pkg::SCENE_STORE_BIT] && !s_q.store_en) |=> $stable(relay_on))
    else $error("refused store moved contact");

  a_recall_apply: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ13
    (wr_scene && !pwdata[ros_pkg::SCENE_STORE_BIT]) |=> s_q.sw == $past(s_q.scenes[snum]))
    else $error("recall did not apply scene");

  a_objbase_read: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ14
    (rd_acc && paddr == ros_pkg::ADDR_OBJBASE)
      |=> prdata == {24'h0, ros_pkg::OBJ_FIRST + {6'h0, CHANNEL} * ros_pkg::OBJ_STRIDE})
    else $error("object base read wrong");

  a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ18
    pready |=> !pready)
    else $error("ready held past one cycle");

  a_err_with_ready: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ18
    pslverr |-> pready)
    else $error("error without ready");

  a_relay_on_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ18
    $changed(relay_on) |-> $past(wr))
    else $error("contact moved without a write");
endmodule : ros_relay_switch
`default_nettype wire

// File: src/ros_pkg.sv
// constants for the relay output switch control block
// assumes a 32-bit apb slave port and one 100 MHz clock
package ros_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OBJ = 8'h04;
  localparam logic [7:0] ADDR_SCENE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_OBJBASE = 8'h10;
  // ----------------------------------------------------------------
  // ctrl fields: config and event strobes
  // ----------------------------------------------------------------
  localparam int CTRL_NC = 0;
  localparam int CTRL_STORE_EN = 1;
  localparam int CTRL_INH_INIT = 2;
  localparam int CTRL_RECOVER = 8;
  localparam int CTRL_DOWNLOAD = 9;
  // ----------------------------------------------------------------
  // object register fields
  // ----------------------------------------------------------------
  localparam int OBJ_SWITCH = 0;
  localparam int OBJ_PERM = 1;
  localparam int OBJ_INHIBIT = 2;
  localparam int OBJ_FORCE_LO = 4;
  localparam int OBJ_STAIR = 6;
  localparam int OBJ_BUSFAIL = 7;
  localparam int OBJ_BUSFAIL_VAL = 8;
  localparam int OBJ_WE_SWITCH = 16;
  localparam int OBJ_WE_PERM = 17;
  localparam int OBJ_WE_INHIBIT = 18;
  localparam int OBJ_WE_FORCE = 19;
  // ----------------------------------------------------------------
  // scene telegram layout and force codes
  // ----------------------------------------------------------------
  localparam int SCENE_STORE_BIT = 7;
  localparam int SCENE_NUM_W = 6;
  localparam int NUM_SCENES = 64;
  localparam logic [1:0] FORCE_OFF = 2'h2;
  localparam logic [1:0] FORCE_ON = 2'h3;
  // ----------------------------------------------------------------
  // object numbering per channel
  // ----------------------------------------------------------------
  localparam logic [7:0] OBJ_FIRST = 8'h0a;
  localparam logic [7:0] OBJ_STRIDE = 8'h08;
endpackage : ros_pkg

// File: verif/ros_bus_node.sv
// bus node model: apb master that carries switch and scene telegrams
// assumes the slave answers with pready and holds nothing after release
`timescale 1ns/1ps
`default_nettype none
module ros_bus_node (
  input wire logic ref_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // request held until pready is sampled high, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // no answer time is assumed; only the bench timeout ends this wait
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data shows the inverse so stale values are not mistaken
    pwdata <= ~d;
  endtask : xfer
endmodule : ros_bus_node
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for one relay channel, channel index 1
// assumes the bus node model drives every apb input
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, relay_on, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  ros_bus_node node (.ref_clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  ros_relay_switch #(.CHANNEL(2'h1)) uut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .relay_on(relay_on));
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    node.xfer(1'b1, a, d, rdat, rerr);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    node.xfer(1'b0, a, 32'h0, rdat, rerr);
  endtask : rd
  // object write, then the contact is judged
  task automatic obj(input logic [31:0] d, input logic exp);
    wr(ros_pkg::ADDR_OBJ, d);
    chk("relay_on", {31'h0, relay_on}, {31'h0, exp});
  endtask : obj
  task automatic t_basic;
    chk("relay_on", {31'h0, relay_on}, 32'h0);
    rd(ros_pkg::ADDR_OBJBASE);
    chk("objbase", rdat, 32'h12);
    rd(8'h20);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rdat, 32'h0);
    obj(32'h10001, 1'b1);
    rd(ros_pkg::ADDR_STATUS);
    chk("status", rdat, 32'h1);
    obj(32'h10000, 1'b0);
    wr(ros_pkg::ADDR_CTRL, 32'h1);
    obj(32'h10001, 1'b0);
    obj(32'h10000, 1'b1);
    wr(ros_pkg::ADDR_CTRL, 32'h0);
    $display("done basic");
  endtask : t_basic
  task automatic t_perm;
    obj(32'h20002, 1'b1);
    obj(32'h10040, 1'b1);
    obj(32'h20040, 1'b1);
    obj(32'h20002, 1'b1);
    wr(ros_pkg::ADDR_CTRL, 32'h100);
    chk("recovery", {31'h0, relay_on}, 32'h0);
    obj(32'h20002, 1'b1);
    wr(ros_pkg::ADDR_CTRL, 32'h200);
    chk("download", {31'h0, relay_on}, 32'h0);
    $display("done perm");
  endtask : t_perm
  task automatic t_inhibit;
    obj(32'h10001, 1'b1);
    obj(32'h40005, 1'b1);
    obj(32'h10040, 1'b0);
    obj(32'h40000, 1'b0);
    obj(32'h00040, 1'b1);
    obj(32'h00000, 1'b0);
    wr(ros_pkg::ADDR_CTRL, 32'h104);
    rd(ros_pkg::ADDR_CTRL);
    chk("ctrl readback", rdat, 32'h4);
    rd(ros_pkg::ADDR_OBJ);
    chk("inhibit init", {31'h0, rdat[ros_pkg::OBJ_INHIBIT]}, 32'h1);
    obj(32'h40000, 1'b0);
    $display("done inhibit");
  endtask : t_inhibit
  task automatic t_force;
    obj(32'h10001, 1'b1);
    for (int c = 0; c < 4; c++)
      obj(32'h80000 | (c << 4), c != 2);
    obj(32'h10000, 1'b1);
    obj(32'h00080, 1'b0);
    obj(32'h00180, 1'b1);
    obj(32'h80000, 1'b0);
    $display("done force");
  endtask : t_force
  task automatic t_scene;
    wr(ros_pkg::ADDR_CTRL, 32'h2);
    obj(32'h10001, 1'b1);
    wr(ros_pkg::ADDR_SCENE, 32'hff);
    obj(32'h10000, 1'b0);
    wr(ros_pkg::ADDR_SCENE, 32'h80);
    wr(ros_pkg::ADDR_SCENE, 32'h3f);
    chk("recall 64", {31'h0, relay_on}, 32'h1);
    wr(ros_pkg::ADDR_SCENE, 32'h40);
    chk("recall 1", {31'h0, relay_on}, 32'h0);
    wr(ros_pkg::ADDR_CTRL, 32'h0);
    obj(32'h10001, 1'b1);
    wr(ros_pkg::ADDR_SCENE, 32'h80);
    obj(32'h10000, 1'b0);
    wr(ros_pkg::ADDR_SCENE, 32'h00);
    chk("store refused", {31'h0, relay_on}, 32'h0);
    rd(ros_pkg::ADDR_SCENE);
    chk("scene read err", {31'h0, rerr}, 32'h1);
    obj(32'h20002, 1'b1);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ros_pkg::ADDR_OBJ);
    chk("perm after reset", {31'h0, rdat[ros_pkg::OBJ_PERM]}, 32'h0);
    $display("done scene");
  endtask : t_scene
  initial
  begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_basic();
    t_perm();
    t_inhibit();
    t_force();
    t_scene();
    summarize();
  end
endmodule : testbench
`default_nettype wire
